// *** lsfp_pkg.sv ***
// package of constants and types for the led string fault protection block
package lsfp_pkg;
    localparam int unsigned CLK_HZ = 200_000_000; // system clock rate
    localparam int unsigned NUM_CH = 8; // gate channels
    localparam int unsigned NUM_CTRL = 4; // pwm control inputs
    // internal timing clock period, in picoseconds (3.2 us)
    localparam int unsigned TICK_PS = 3_200_000;
    localparam int unsigned TICK_CYC = TICK_PS / 5000; // 640 system cycles per tick
    // settle and qualify delays, in internal ticks (12.8 us each)
    localparam int unsigned SETTLE_TICKS = 4;
    localparam int unsigned QUALIFY_TICKS = 4;
    // fault output toggle frequency, in hz
    localparam int unsigned FLT_HZ = 80_000;
    localparam int unsigned FLT_PER_CYC = CLK_HZ / FLT_HZ; // 2500 cycles
    localparam int unsigned FLT_Q1_CYC = FLT_PER_CYC / 4; // 25% low time
    localparam int unsigned FLT_Q2_CYC = FLT_PER_CYC / 2; // 50% low time
    localparam int unsigned FLT_Q3_CYC = (FLT_PER_CYC * 3) / 4; // 75% low time
    // headroom modes
    localparam logic [1:0] MODE_2CH = 2'h0;
    localparam logic [1:0] MODE_4CH = 2'h1;
    localparam logic [1:0] MODE_8CH = 2'h2;
    // fault codes, ascending severity
    typedef enum logic [2:0] {
        FC_NONE = 3'h0,
        FC_LED_OPEN = 3'h1,
        FC_LED_SHORT = 3'h2,
        FC_FET_OPEN = 3'h3,
        FC_FULL = 3'h4
    } lsfp_fault_t;
endpackage

// *** lsfp_tick.sv ***
// divider making the 3.2 us internal tick enable pulse
`timescale 1ns/1ps
module lsfp_tick
    import lsfp_pkg::*;
(
    input wire logic clk_in, // system clock
    input wire logic rst_b_in, // sync reset, active low
    output logic tick_out // one-cycle pulse every tick period
);
    typedef struct packed {
        logic [9:0] cnt; // cycle counter
        logic tick; // registered pulse
    } lsfp_tick_st_t;
    lsfp_tick_st_t s_q, s_d;
    localparam logic [9:0] TICK_LAST = 10'(TICK_CYC - 1);

    // count up and wrap, pulse on wrap
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt == TICK_LAST) begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 10'h001;
        end
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_out = s_q.tick;
endmodule

// *** lsfp_flt_out.sv ***
// fault output pattern generator: 80 khz, duty set by fault code
`timescale 1ns/1ps
module lsfp_flt_out
    import lsfp_pkg::*;
(
    input wire logic clk_in, // system clock
    input wire logic rst_b_in, // sync reset, active low
    input wire lsfp_fault_t code_in, // fault code to report
    output logic low_out // high while the open-drain pin is pulled low
);
    typedef struct packed {
        logic [11:0] cnt; // position inside the period
        logic low; // registered pull-low
    } lsfp_fo_st_t;
    lsfp_fo_st_t s_q, s_d;
    localparam logic [11:0] PER_LAST = 12'(FLT_PER_CYC - 1);

    // low-time lookup per code
    function automatic logic [11:0] low_len(input lsfp_fault_t c);
        case (c)
            FC_LED_OPEN: low_len = 12'(FLT_Q1_CYC);
            FC_LED_SHORT: low_len = 12'(FLT_Q2_CYC);
            FC_FET_OPEN: low_len = 12'(FLT_Q3_CYC);
            default: low_len = 12'h000;
        endcase
    endfunction

    // free running period counter; compare against low time
    always_comb begin
        s_d = s_q;
        s_d.cnt = (s_q.cnt == PER_LAST) ? 12'h000 : s_q.cnt + 12'h001;
        if (code_in == FC_FULL) begin
            s_d.low = 1'b1; // continuous low
        end else if (code_in == FC_NONE) begin
            s_d.low = 1'b0; // released
        end else begin
            s_d.low = (s_q.cnt < low_len(code_in));
        end
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign low_out = s_q.low;
endmodule

// *** lsfp_top.sv ***
// led string fault qualification, latching and fault reporting
// Operation
// - shut channel off before fault signalling
// - fault output toggles at 80 khz
// - duty 25/50/75 percent, full for fet short
// - open led: drain low while on, latched
// - shorted led: drain high, latched
// - open fet: source low, latched
// - shorted fet watched continuously
// - shorted fet unlatched, clears below hysteresis
// - led and open-fet checks only while on
// - wait settle delay after turn-on
// - abnormal result persists qualify delay first
// - latches held until enable toggle or por; undervoltage also clears them here
// - thermal: all off, latched, same release
// - thermal shows continuous low fault
// - undervoltage keeps everything in standby
// - short threshold selectable only in 4/8ch
// - enable gates pwm; pwm pairs channels in 2ch mode
// - internal tick 3.2 us, delays four ticks
`timescale 1ns/1ps
module lsfp_top
    import lsfp_pkg::*;
(
    input wire logic clk_in, // system clock 200 mhz
    input wire logic rst_b_in, // sync reset, active low
    input wire logic enable_in, // global enable from controller
    input wire logic [NUM_CTRL-1:0] pwm_ctrl_in, // pwm inputs, one per channel pair in 2ch mode
    input wire logic [1:0] mode_in, // headroom mode from strap comparators
    input wire logic [NUM_CH-1:0] drain_low_in, // drain below 0.8 v
    input wire logic [NUM_CH-1:0] drain_high_in, // drain above 19.2 v
    input wire logic [NUM_CH-1:0] drain_ref_high_in, // drain above 8x lsd_ref_in
    input wire logic [NUM_CH-1:0] src_low_dim_in, // source below analog_dim_in/4
    input wire logic [NUM_CH-1:0] src_low_fix_in, // source below 0.3 v
    input wire logic dim_high_in, // analog_dim_in above 1.4 v
    input wire logic [NUM_CH-1:0] src_high_in, // source above 0.9 v
    input wire logic [NUM_CH-1:0] src_clear_in, // source below 0.7 v
    input wire logic over_temp_in, // die above 160 c
    input wire logic supply_ok_in, // supply above 7.0 v
    output logic [NUM_CH-1:0] gate_drive_out, // gate enable per channel
    output logic regulator_en_out, // internal_regulator enable
    output logic fault_out_n_out, // open-drain fault pin level, always 0
    output logic fault_out_n_oe_out, // high while pulling the fault pin low
    output logic [NUM_CH-1:0] led_open_fault_out, // latched open led per channel
    output logic [NUM_CH-1:0] led_short_fault_out, // latched shorted led per channel
    output logic [NUM_CH-1:0] fet_open_fault_out, // latched open fet per channel
    output logic [NUM_CH-1:0] fet_short_fault_out, // live shorted fet per channel
    output logic thermal_fault_out // latched thermal shutdown
);
    // per channel qualification states
    typedef enum logic [3:0] {
        CH_OFF = 4'h1, // channel not commanded on
        CH_SETTLE = 4'h2, // waiting settle_delay
        CH_WATCH = 4'h4, // sampling comparators
        CH_QUAL = 4'h8 // abnormal, counting qualify_delay
    } lsfp_ch_t;

    typedef struct packed {
        lsfp_ch_t [NUM_CH-1:0] st; // channel state
        logic [NUM_CH-1:0][2:0] cnt; // tick counter per channel
        logic [NUM_CH-1:0] lo; // latched open led
        logic [NUM_CH-1:0] ls; // latched shorted led
        logic [NUM_CH-1:0] fo; // latched open fet
        logic [NUM_CH-1:0] fs; // live shorted fet
        logic th; // latched thermal
        logic [1:0] en_seq; // enable release sequence: 0 idle,1 saw low
        logic en_prev; // enable a cycle ago
        logic [NUM_CH-1:0] gate; // gate outputs
        logic reg_en; // regulator enable
        lsfp_fault_t code; // fault code for output pattern
        logic [NUM_CH-1:0] fault_vis; // faults whose channel is already off
    } lsfp_st_t;

    lsfp_st_t s_q, s_d;
    logic tick; // internal 3.2 us enable
    logic flt_low; // pattern generator output

    localparam logic [2:0] SETTLE_LAST = 3'(SETTLE_TICKS);
    localparam logic [2:0] QUAL_LAST = 3'(QUALIFY_TICKS);

    // map pwm input to channel command for a headroom mode
    function automatic logic [NUM_CH-1:0] ch_cmd(input logic [1:0] m,
                                                 input logic [NUM_CTRL-1:0] p);
        logic [NUM_CH-1:0] r;
        r = '0;
        if (m == MODE_8CH) begin
            r = {NUM_CH{p[0]}}; // one input drives all strings
        end else if (m == MODE_4CH) begin
            r = {p[2], p[2], p[0], p[0], p[2], p[2], p[0], p[0]};
        end else begin
            r = {p[3], p[3], p[2], p[2], p[1], p[1], p[0], p[0]};
        end
        return r;
    endfunction

    lsfp_tick u_tick (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .tick_out(tick)
    );

    lsfp_flt_out u_flt (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .code_in(s_q.code),
        .low_out(flt_low)
    );

    // next state: qualification, latching, release and priority
    always_comb begin
        logic [NUM_CH-1:0] cmd;
        logic [NUM_CH-1:0] bad_lo;
        logic [NUM_CH-1:0] bad_ls;
        logic [NUM_CH-1:0] bad_fo;
        logic [NUM_CH-1:0] latched;
        logic release_ev;
        cmd = '0;
        bad_lo = '0;
        bad_ls = '0;
        bad_fo = '0;
        latched = '0;
        release_ev = 1'b0;
        s_d = s_q;
        s_d.en_prev = enable_in;
        // release needs high, low, high on enable
        if (s_q.en_prev && !enable_in) begin
            s_d.en_seq = 2'h1; // saw the falling edge
        end else if (!s_q.en_prev && enable_in && s_q.en_seq == 2'h1) begin
            release_ev = 1'b1;
            s_d.en_seq = 2'h0;
        end
        // channels commanded on only while enabled
        cmd = enable_in ? ch_cmd(mode_in, pwm_ctrl_in) : '0;
        // comparator selection for thresholds
        bad_lo = drain_low_in;
        // short threshold from lsd_ref_in only in 4/8ch modes
        bad_ls = (mode_in == MODE_2CH) ? drain_high_in : drain_ref_high_in;
        bad_fo = dim_high_in ? src_low_fix_in : src_low_dim_in;
        if (release_ev) begin
            s_d.lo = '0;
            s_d.ls = '0;
            s_d.fo = '0;
            s_d.th = 1'b0;
        end
        // thermal latches; set wins over release
        if (over_temp_in) begin
            s_d.th = 1'b1;
        end
        // shorted fet: continuous, self-clearing with hysteresis
        for (int i = 0; i < NUM_CH; i++) begin
            if (src_high_in[i]) begin
                s_d.fs[i] = 1'b1;
            end else if (src_clear_in[i]) begin
                s_d.fs[i] = 1'b0;
            end
        end
        latched = s_d.lo | s_d.ls | s_d.fo;
        // per channel settle and qualify sequencing on the tick
        for (int i = 0; i < NUM_CH; i++) begin
            if (!cmd[i] || latched[i]) begin
                s_d.st[i] = CH_OFF; // checks idle while off
                s_d.cnt[i] = '0;
            end else begin
                case (s_q.st[i])
                    CH_OFF: begin
                        s_d.st[i] = CH_SETTLE;
                        s_d.cnt[i] = '0;
                    end
                    CH_SETTLE: begin
                        if (tick) begin
                            s_d.cnt[i] = s_q.cnt[i] + 3'h1;
                            if (s_q.cnt[i] + 3'h1 == SETTLE_LAST) begin
                                s_d.st[i] = CH_WATCH;
                                s_d.cnt[i] = '0;
                            end
                        end
                    end
                    CH_WATCH: begin
                        if (bad_lo[i] || bad_ls[i] || bad_fo[i]) begin
                            s_d.st[i] = CH_QUAL;
                            s_d.cnt[i] = '0;
                        end
                    end
                    CH_QUAL: begin
                        if (!(bad_lo[i] || bad_ls[i] || bad_fo[i])) begin
                            s_d.st[i] = CH_WATCH; // glitch rejected
                        end else if (tick) begin
                            s_d.cnt[i] = s_q.cnt[i] + 3'h1;
                            if (s_q.cnt[i] + 3'h1 == QUAL_LAST) begin
                                s_d.lo[i] = bad_lo[i];
                                s_d.ls[i] = bad_ls[i];
                                s_d.fo[i] = bad_fo[i];
                                s_d.st[i] = CH_OFF;
                            end
                        end
                    end
                    default: begin
                        s_d.st[i] = CH_OFF;
                    end
                endcase
            end
        end
        latched = s_d.lo | s_d.ls | s_d.fo;
        // gates off on any latched fault, thermal or undervoltage
        if (!supply_ok_in || s_d.th) begin
            s_d.gate = '0;
        end else begin
            s_d.gate = cmd & ~latched & ~s_d.fs;
        end
        s_d.reg_en = supply_ok_in && !s_d.th;
        // report only faults whose gate is already off: gate drops this edge,
        // code follows two cycles later so the channel is off first
        s_d.fault_vis = s_q.lo | s_q.ls | s_q.fo | s_q.fs;
        if (!supply_ok_in) begin
            s_d.code = FC_NONE; // standby, nothing reported
        end else if (s_q.th || (|(s_q.fs & s_q.fault_vis))) begin
            s_d.code = FC_FULL;
        end else if (|(s_q.fo & s_q.fault_vis)) begin
            s_d.code = FC_FET_OPEN;
        end else if (|(s_q.ls & s_q.fault_vis)) begin
            s_d.code = FC_LED_SHORT;
        end else if (|(s_q.lo & s_q.fault_vis)) begin
            s_d.code = FC_LED_OPEN;
        end else begin
            s_d.code = FC_NONE;
        end
        // undervoltage clears the latches, thermal, release sequence and channel states
        if (!supply_ok_in) begin
            s_d.lo = '0;
            s_d.ls = '0;
            s_d.fo = '0;
            s_d.th = 1'b0;
            s_d.en_seq = 2'h0;
            for (int i = 0; i < NUM_CH; i++) begin
                s_d.st[i] = CH_OFF;
                s_d.cnt[i] = '0;
            end
        end
    end

    // state register; channels reset to off
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            s_q <= '0;
            s_q.st <= {NUM_CH{CH_OFF}};
            s_q.code <= FC_NONE;
        end else begin
            s_q <= s_d;
        end
    end

    // registered outputs
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            fault_out_n_oe_out <= 1'b0;
        end else begin
            fault_out_n_oe_out <= flt_low;
        end
    end

    assign fault_out_n_out = 1'b0; // open drain only ever pulls low
    assign gate_drive_out = s_q.gate;
    assign regulator_en_out = s_q.reg_en;
    assign led_open_fault_out = s_q.lo;
    assign led_short_fault_out = s_q.ls;
    assign fet_open_fault_out = s_q.fo;
    assign fet_short_fault_out = s_q.fs;
    assign thermal_fault_out = s_q.th;

    // a latched channel never has its gate on, not even for one cycle
    gate_off_fault_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (gate_drive_out & (s_q.lo | s_q.ls | s_q.fo)) == '0)
        else $error("gate on with latched fault");

    // thermal latch drops every gate and the regulator
    thermal_all_off_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        thermal_fault_out |-> (gate_drive_out == '0 && !regulator_en_out))
        else $error("thermal did not shut down");

    // undervoltage holds gates off and clears the thermal latch
    uvlo_standby_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !supply_ok_in |=> (gate_drive_out == '0 && !thermal_fault_out))
        else $error("undervoltage not in standby");

    // undervoltage also clears the fault code and drops the regulator
    uv_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !supply_ok_in |=> (s_q.code == FC_NONE && !regulator_en_out))
        else $error("undervoltage left output active");

    // pin follows the code two cycles later, so three cycles of code suffice
    full_low_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (s_q.code == FC_FULL) [*3] |-> fault_out_n_oe_out)
        else $error("full fault not continuous low");

    // no fault code for three cycles means the pin is released
    oe_idle_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (s_q.code == FC_NONE) [*3] |-> !fault_out_n_oe_out)
        else $error("fault pin low with no fault");

    // live fet short flag tracks its comparators with hysteresis
    fet_short_set_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (src_high_in[0] && supply_ok_in) |=> fet_short_fault_out[0])
        else $error("fet short not flagged");
    fet_short_clr_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (src_clear_in[0] && !src_high_in[0]) |=> !fet_short_fault_out[0])
        else $error("fet short not cleared");

    // a live fet short keeps its gate low
    short_gate_low_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (fet_short_fault_out & gate_drive_out) == '0)
        else $error("gate on with fet short");

    // detectors rest while off and only watch after settling
    off_no_check_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !enable_in |=> (s_q.st[0] == CH_OFF))
        else $error("detector active while off");
    settle_wait_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        $rose(s_q.st[0] == CH_WATCH) |-> $past(s_q.st[0] == CH_SETTLE || s_q.st[0] == CH_QUAL))
        else $error("watch entered without settle");

    // a channel leaving off always passes through settle first
    no_skip_settle_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (s_q.st[0] == CH_OFF) |=> (s_q.st[0] != CH_WATCH && s_q.st[0] != CH_QUAL))
        else $error("settle delay skipped");

    // latches come only from qualification and hold until released
    latch_via_qual_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        ($rose(led_open_fault_out[0]) && supply_ok_in) |-> $past(s_q.st[0] == CH_QUAL))
        else $error("latched without qualification");
    hold_latch_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (led_open_fault_out[0] && enable_in && supply_ok_in && $past(enable_in))
        |=> led_open_fault_out[0])
        else $error("latch lost without release");

    // a completed enable toggle clears every latch
    release_clear_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        ($rose(enable_in) && s_q.en_seq == 2'h1 && !over_temp_in) |=>
        ((s_q.lo | s_q.ls | s_q.fo) == '0 && !thermal_fault_out))
        else $error("release did not clear latches");
endmodule

// *** lsfp_host.sv ***
// host controller model driving enable and the pwm inputs
`timescale 1ns/1ps
module lsfp_host (
    input wire logic clk_in, // system clock
    input wire logic [3:0] pwm_req_in, // pwm levels wanted by the bench
    input wire logic rel_in, // ask for a release toggle of enable
    output logic enable_out, // global enable to the block
    output logic [3:0] pwm_out // pwm levels to the block
);
    logic [1:0] seq_q; // release toggle phase, 0 = idle
    initial begin
        enable_out = 1'b0;
        pwm_out = 4'h0;
        seq_q = 2'h0;
    end
    // enable stays high so pwm takes effect; release drops it three cycles
    always @(posedge clk_in) begin
        pwm_out <= pwm_req_in;
        if (rel_in && seq_q == 2'h0) begin
            seq_q <= 2'h3;
            enable_out <= 1'b0;
        end else if (seq_q != 2'h0) begin
            seq_q <= seq_q - 2'h1;
            enable_out <= (seq_q == 2'h1);
        end else begin
            enable_out <= 1'b1;
        end
    end
endmodule

// *** lsfp_top_tb.sv ***
// self-checking testbench for the led string fault protection block
`timescale 1ns/1ps
module lsfp_top_tb
    import lsfp_pkg::*;
;
    logic clk_in, rst_b_in, rel, enable_in, dim_high_in, over_temp_in, supply_ok_in;
    logic [3:0] pwm_req, pwm_ctrl_in; // bench request and host output
    logic [1:0] mode_in; // headroom strap mode
    logic [7:0] drain_low_in, drain_high_in, drain_ref_high_in; // drain comparators
    logic [7:0] src_low_dim_in, src_low_fix_in, src_high_in, src_clear_in; // source comps
    logic [7:0] gate_drive_out, led_open_fault_out, led_short_fault_out;
    logic [7:0] fet_open_fault_out, fet_short_fault_out;
    logic regulator_en_out, fault_out_n_out, fault_out_n_oe_out, thermal_fault_out;
    logic [31:0] exp_q[$]; // expected results, oldest first
    logic [31:0] got_v, exp_v; // observed result and its note
    logic got_vld; // a result is presented to the monitor
    int bad_count, n_checks, seed, i, n;
    logic [3:0] p;
    logic [1:0] md;

    lsfp_host u_host (.clk_in(clk_in), .pwm_req_in(pwm_req), .rel_in(rel),
        .enable_out(enable_in), .pwm_out(pwm_ctrl_in));
    lsfp_top DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .enable_in(enable_in),
        .pwm_ctrl_in(pwm_ctrl_in), .mode_in(mode_in), .drain_low_in(drain_low_in),
        .drain_high_in(drain_high_in), .drain_ref_high_in(drain_ref_high_in),
        .src_low_dim_in(src_low_dim_in), .src_low_fix_in(src_low_fix_in),
        .dim_high_in(dim_high_in), .src_high_in(src_high_in), .src_clear_in(src_clear_in),
        .over_temp_in(over_temp_in), .supply_ok_in(supply_ok_in),
        .gate_drive_out(gate_drive_out), .regulator_en_out(regulator_en_out),
        .fault_out_n_out(fault_out_n_out), .fault_out_n_oe_out(fault_out_n_oe_out),
        .led_open_fault_out(led_open_fault_out), .led_short_fault_out(led_short_fault_out),
        .fet_open_fault_out(fet_open_fault_out), .fet_short_fault_out(fet_short_fault_out),
        .thermal_fault_out(thermal_fault_out));

    // 200 mhz system clock
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    // monitor: pairs each presented result with the oldest note
    always @(posedge clk_in) begin
        if (got_vld === 1'b1) begin
            exp_v = exp_q.pop_front();
            n_checks++;
            if (got_v !== exp_v) begin
                bad_count++;
                $display("mismatch at %0t: got %h expected %h", $time, got_v, exp_v);
            end
        end
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_in);
    endtask

    // two edges per check so the valid strobe is never written twice in a step
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        exp_q.push_back(exp);
        got_v <= got;
        got_vld <= 1'b1;
        @(posedge clk_in);
        got_vld <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic finish_test;
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // a full pattern period holds the low time exactly, whatever the phase
    task automatic low_cycles(output int k);
        k = 0;
        repeat (FLT_PER_CYC) begin
            @(posedge clk_in);
            if (fault_out_n_oe_out === 1'b1) k++;
        end
    endtask

    // bounded wait for any fault flag; unknown flags end the wait and fail later
    task automatic wait_any(input int lim, output int k);
        k = 0;
        while (k < lim && (led_open_fault_out | led_short_fault_out | fet_open_fault_out
               | fet_short_fault_out | {8{thermal_fault_out}}) === 8'h00) begin
            @(posedge clk_in);
            k++;
        end
    endtask

    task automatic clear_in;
        drain_low_in <= 8'h00;
        drain_high_in <= 8'h00;
        drain_ref_high_in <= 8'h00;
        src_low_dim_in <= 8'h00;
        src_low_fix_in <= 8'h00;
        src_high_in <= 8'h00;
        src_clear_in <= 8'hff;
        over_temp_in <= 1'b0;
    endtask

    function automatic logic [7:0] exp_gate(input logic [1:0] m, input logic [3:0] c);
        if (m == MODE_4CH) return {{2{c[2]}}, {2{c[0]}}, {2{c[2]}}, {2{c[0]}}};
        if (m == MODE_8CH) return {8{c[0]}};
        return {{2{c[3]}}, {2{c[2]}}, {2{c[1]}}, {2{c[0]}}};
    endfunction

    // one latched fault: timing, isolation, duty, hold and release
    task automatic run_fault(input logic [1:0] m, input logic dh, input logic [7:0] v0,
        input logic [7:0] v1, v2, v3, v4, input logic [23:0] fl, input logic [7:0] g,
        input int lows);
        int k;
        mode_in <= m;
        dim_high_in <= dh;
        drain_low_in <= v0;
        drain_high_in <= v1;
        drain_ref_high_in <= v2;
        src_low_dim_in <= v3;
        src_low_fix_in <= v4;
        pwm_req <= 4'h1;
        wait_any(9000, k);
        chk({fault_out_n_oe_out, gate_drive_out}, {1'b0, g});
        chk(k >= 3830 && k <= 5140, 1);
        chk({fet_open_fault_out, led_short_fault_out, led_open_fault_out}, fl);
        low_cycles(k);
        chk(k, lows);
        clear_in;
        cyc(100);
        chk({fet_open_fault_out, led_short_fault_out, led_open_fault_out}, fl);
        rel <= 1'b1;
        cyc(1);
        rel <= 1'b0;
        cyc(10);
        pwm_req <= 4'h0;
        chk({fet_open_fault_out, led_short_fault_out, led_open_fault_out}, 0);
    endtask

    // main sequence
    initial begin
        seed = 32'h186a280d;
        bad_count = 0;
        n_checks = 0;
        got_vld = 1'b0;
        got_v = 32'h0;
        rst_b_in = 1'b0;
        rel = 1'b0;
        pwm_req = 4'h0;
        mode_in = MODE_2CH;
        dim_high_in = 1'b0;
        supply_ok_in = 1'b1;
        clear_in;
        cyc(12);
        rst_b_in <= 1'b1;
        cyc(1);
        chk({fault_out_n_out, fault_out_n_oe_out, gate_drive_out, thermal_fault_out}, 0);
        chk(regulator_en_out, 1);
        // random pwm and strap mode, then enable low drops every channel
        for (i = 0; i < 8; i++) begin
            p = $random(seed);
            md = $unsigned($random(seed)) % 3;
            pwm_req <= p;
            mode_in <= md;
            cyc(3);
            chk(gate_drive_out, exp_gate(md, p));
            rel <= 1'b1;
            cyc(1);
            rel <= 1'b0;
            cyc(2);
            chk(gate_drive_out, 0);
        end
        // comparators on an off channel, or the wrong short threshold, are ignored
        mode_in <= MODE_2CH;
        pwm_req <= 4'h1;
        drain_low_in <= 8'h0c;
        drain_ref_high_in <= 8'h01;
        cyc(6000);
        chk({fet_open_fault_out, led_short_fault_out, led_open_fault_out}, 0);
        clear_in;
        pwm_req <= 4'h0;
        cyc(4);
        run_fault(MODE_2CH, 0, 8'h01, 0, 0, 0, 0, 24'h000001, 8'h02, FLT_Q1_CYC);
        run_fault(MODE_2CH, 0, 0, 8'h01, 0, 0, 0, 24'h000100, 8'h02, FLT_Q2_CYC);
        run_fault(MODE_4CH, 0, 0, 0, 8'h01, 0, 0, 24'h000100, 8'h32, FLT_Q2_CYC);
        run_fault(MODE_2CH, 0, 0, 0, 0, 8'h01, 8'h02, 24'h010000, 8'h02, FLT_Q3_CYC);
        run_fault(MODE_2CH, 1, 8'h01, 0, 0, 0, 8'h02, 24'h020001, 8'h00, FLT_Q3_CYC);
        // shorted fet on an off channel, unlatched
        src_high_in <= 8'h08;
        src_clear_in <= 8'hf7;
        wait_any(5200, n);
        chk(fet_short_fault_out, 8'h08);
        cyc(4); // pin pattern lags the flag by four cycles
        low_cycles(n);
        chk(n, FLT_PER_CYC);
        src_high_in <= 8'h00;
        src_clear_in <= 8'hff;
        cyc(10);
        chk({fet_short_fault_out, fault_out_n_oe_out}, 0);
        // thermal shutdown latches past the cause, released by toggle
        pwm_req <= 4'hf;
        cyc(5);
        over_temp_in <= 1'b1;
        wait_any(5200, n);
        cyc(4);
        chk({regulator_en_out, gate_drive_out, thermal_fault_out}, 10'h001);
        over_temp_in <= 1'b0;
        low_cycles(n);
        chk(n, FLT_PER_CYC);
        rel <= 1'b1;
        cyc(1);
        rel <= 1'b0;
        cyc(10);
        chk({regulator_en_out, thermal_fault_out}, 2'h2);
        // undervoltage keeps the channels and regulator off
        supply_ok_in <= 1'b0;
        cyc(3);
        chk({regulator_en_out, gate_drive_out}, 0);
        supply_ok_in <= 1'b1;
        finish_test;
    end

    // watchdog sized well beyond the full sequence
    initial begin
        #400000;
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        finish_test;
    end
endmodule
